// *** shared/pdc_pkg.sv ***
// Package for the prescaled down counter: data-space map, fields, reset values
package pdc_pkg;

  // ****************************************************
  // Data-space locations
  // ****************************************************
  localparam logic [7:0] PDC_ADDR_PRESC = 8'hD2;
  localparam logic [7:0] PDC_ADDR_COUNT = 8'hD3;
  localparam logic [7:0] PDC_ADDR_CTL   = 8'hD4;

  // ****************************************************
  // Control register fields
  // ****************************************************
  localparam int PDC_CTL_ZERO_BIT  = 7;  // count_zero_flag
  localparam int PDC_CTL_IRQ_BIT   = 6;  // zero_irq_enable
  localparam int PDC_CTL_DIR_BIT   = 5;  // pin_direction_select
  localparam int PDC_CTL_DOUT_BIT  = 4;  // pin data / mode select
  localparam int PDC_CTL_RUN_BIT   = 3;  // prescale_run
  localparam int PDC_CTL_TAP_MSB   = 2;  // tap_select_bit2..0
  localparam int PDC_CTL_TAP_LSB   = 0;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] PDC_COUNT_RESET = 8'hFF;
  localparam logic [6:0] PDC_PRESC_RESET = 7'h7F;
  localparam logic [7:0] PDC_CTL_RESET   = 8'h00;
  localparam logic [7:0] PDC_COUNT_ZERO  = 8'h00;
  localparam logic [7:0] PDC_READ_NONE   = 8'h00;

  // ****************************************************
  // Timing: oscillator divided by twelve
  // ****************************************************
  localparam int         PDC_OSC_DIV      = 12;
  localparam logic [3:0] PDC_OSC_DIV_LAST = 4'(PDC_OSC_DIV - 1);
  localparam logic [3:0] PDC_OSC_DIV_ZERO = 4'h0;

  // ****************************************************
  // Tap codes
  // ****************************************************
  localparam logic [2:0] PDC_TAP_DIRECT = 3'h0;

endpackage : pdc_pkg

// *** rtl/pdc_timer.sv ***
// Prescaled down counter: 7-bit prescaler, 8-bit counter, timer pin logic
`timescale 1ns/100ps

// Behaviour
// - Count register at D3h, readable and writable like RAM.
// - Prescaler state readable at D2h.
// - Control and status bits live at D4h.
// - Count decrements on selected tap rising edge; zero sets zero flag.
// - Zero flag with interrupt enable set raises the interrupt request.
// - The interrupt request can wake the processor from wait.
// - Prescaler fed by oscillator/12 or timer pin, decrements on rising edge.
// - Factor one uses prescaler input; factor 2^n uses prescaler bit n-1.
// - Run bit low forces prescaler to all ones and stops counting.
// - Prescaler write accepted only while the run bit is one.
// - Gated mode counts oscillator/12 only while the pin is high.
// - Clock-input mode counts pin rising edges; source keeps rate limited.
// - Output mode drives pin from latch; prescaler runs from oscillator/12.
// - Output latch transparent while zero flag high, holds when it falls.
// - Writing 00h to count or one to control bit 7 sets zero flag.
// - Reset loads count FFh, prescaler 7Fh, clears control.
// - Count write beats a coincident decrement to zero; no flag then unless 00h is written.
// - Count and prescaler read back exact current values at any time.
// - Tap code 000 to 111 selects division 1 up to 128.
module pdc_timer
  import pdc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  input  wire logic       timer_pin_in,
  output logic            timer_pin_out,
  output logic            timer_pin_oe,
  output logic            zero_irq
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [7:0] count;
    logic [6:0] presc;
    logic [7:0] ctl;
    logic [3:0] div;
    logic       sync1;
    logic       sync2;
    logic       pin_prev;
    logic       out_latch;
    logic [7:0] rdata;
  } pdc_state_s;

  localparam pdc_state_s PDC_STATE_RESET = '{
    count:     PDC_COUNT_RESET,
    presc:     PDC_PRESC_RESET,
    ctl:       PDC_CTL_RESET,
    div:       PDC_OSC_DIV_ZERO,
    sync1:     1'b0,
    sync2:     1'b0,
    pin_prev:  1'b0,
    out_latch: 1'b0,
    rdata:     PDC_READ_NONE
  };

  pdc_state_s state_r;
  pdc_state_s state_nxt;

  // ****************************************************
  // Helpers
  // ****************************************************
  // Prescaler bit that feeds the counter for a tap code above zero
  function automatic logic pdc_tap_bit(input logic [6:0] presc,
                                       input logic [2:0] tap);
    logic [2:0] idx;
    idx = 3'(tap - 3'h1);
    return presc[idx];
  endfunction : pdc_tap_bit

  // Named views of control fields
  logic       zero_flag;
  logic       irq_en;
  logic       dir_out;
  logic       dout;
  logic       run;
  logic [2:0] tap;
  logic       osc_tick;
  logic       pin_rise;
  logic       presc_clk;
  logic       count_clk;
  logic [6:0] presc_dec;
  logic       wr_presc;
  logic       wr_count;
  logic       wr_ctl;
  logic       hit_zero;

  // Field decode from the current control register
  always_comb begin
    zero_flag = state_r.ctl[PDC_CTL_ZERO_BIT];
    irq_en    = state_r.ctl[PDC_CTL_IRQ_BIT];
    dir_out   = state_r.ctl[PDC_CTL_DIR_BIT];
    dout      = state_r.ctl[PDC_CTL_DOUT_BIT];
    run       = state_r.ctl[PDC_CTL_RUN_BIT];
    tap       = state_r.ctl[PDC_CTL_TAP_MSB:PDC_CTL_TAP_LSB];
  end

  // Write strobes, plain decode of the data-space address
  always_comb begin
    wr_presc = 1'b0;
    wr_count = 1'b0;
    wr_ctl   = 1'b0;
    if (wr_en && addr == PDC_ADDR_PRESC) begin
      wr_presc = 1'b1;
    end else if (wr_en && addr == PDC_ADDR_COUNT) begin
      wr_count = 1'b1;
    end else if (wr_en && addr == PDC_ADDR_CTL) begin
      wr_ctl = 1'b1;
    end
  end

  // ****************************************************
  // Prescaler clock source
  // ****************************************************
  // Oscillator/12 strobe and synchronised pin edge; only sync2 and its delayed copy pin_prev are looked at
  always_comb begin
    osc_tick = (state_r.div == PDC_OSC_DIV_LAST);
    pin_rise = state_r.sync2 & ~state_r.pin_prev;
    if (dir_out) begin
      presc_clk = osc_tick;
    end else if (dout) begin
      presc_clk = osc_tick & state_r.sync2;
    end else begin
      presc_clk = pin_rise;
    end
  end

  // Tap selection: the counter sees every prescaler event for tap zero, else a rising edge of the chosen prescaler bit
  always_comb begin
    presc_dec = 7'(state_r.presc - 7'h01);
    if (!run || wr_presc) begin
      count_clk = 1'b0;
    end else if (tap == PDC_TAP_DIRECT) begin
      count_clk = presc_clk;
    end else begin
      count_clk = presc_clk
                & ~pdc_tap_bit(state_r.presc, tap)
                & pdc_tap_bit(presc_dec, tap);
    end
    hit_zero = count_clk && !wr_count && (state_r.count == 8'h01);
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    state_nxt = state_r;

    // Oscillator divider and pin synchroniser run freely
    state_nxt.div      = osc_tick ? PDC_OSC_DIV_ZERO : 4'(state_r.div + 4'h1);
    state_nxt.sync1    = timer_pin_in;
    state_nxt.sync2    = state_r.sync1;
    state_nxt.pin_prev = state_r.sync2;

    // Control register; a write may clear the zero flag
    if (wr_ctl) begin
      state_nxt.ctl = wdata;
    end

    // Prescaler: forced to all ones while stopped, loads only while running
    if (!state_nxt.ctl[PDC_CTL_RUN_BIT]) begin
      state_nxt.presc = PDC_PRESC_RESET;
    end else if (wr_presc && run) begin
      state_nxt.presc = wdata[6:0];
    end else if (run && presc_clk) begin
      state_nxt.presc = presc_dec;
    end

    // Counter: a write takes precedence over a decrement
    if (wr_count) begin
      state_nxt.count = wdata;
    end else if (count_clk) begin
      state_nxt.count = 8'(state_r.count - 8'h01);
    end

    // Hardware set of the zero flag wins over a software clear
    if (hit_zero) begin
      state_nxt.ctl[PDC_CTL_ZERO_BIT] = 1'b1;
    end
    if (wr_count && wdata == PDC_COUNT_ZERO) begin
      state_nxt.ctl[PDC_CTL_ZERO_BIT] = 1'b1;
    end

    // Output latch follows the data bit while the flag is high
    if (zero_flag) begin
      state_nxt.out_latch = dout;
    end

    // Read data registered; values are the live registers at the read
    if (rd_en && addr == PDC_ADDR_PRESC) begin
      state_nxt.rdata = {1'b0, state_r.presc};
    end else if (rd_en && addr == PDC_ADDR_COUNT) begin
      state_nxt.rdata = state_r.count;
    end else if (rd_en && addr == PDC_ADDR_CTL) begin
      state_nxt.rdata = state_r.ctl;
    end else if (rd_en) begin
      state_nxt.rdata = PDC_READ_NONE;
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  // Synchronous active-low reset to constants only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= PDC_STATE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // In output mode the pin is transparent to the data bit while the flag is set, else the held latch.
  // The irq also serves as the wake request, so no separate wake line is needed.
  always_comb begin
    rdata         = state_r.rdata;
    timer_pin_oe  = dir_out;
    timer_pin_out = dir_out & (zero_flag ? dout : state_r.out_latch);
    zero_irq      = zero_flag & irq_en;
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking pdc_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence pdc_tick_gap_s;
    (!osc_tick) [*8] ##1 !osc_tick ##1 !osc_tick ##1 !osc_tick ##1 osc_tick;
  endsequence

  sequence pdc_zero_dec_s;
    count_clk && !wr_count && state_r.count == 8'h01;
  endsequence

  osc_period_a: assert property (
    osc_tick |=> pdc_tick_gap_s
  ) else $error("oscillator/12 strobe period is not twelve cycles");

  count_write_a: assert property (
    wr_count |=> state_r.count == $past(wdata)
  ) else $error("count write not applied");

  zero_set_a: assert property (
    pdc_zero_dec_s |=> zero_flag && state_r.count == 8'h00
  ) else $error("decrement to zero did not set the flag");

  zero_write_a: assert property (
    wr_count && wdata == 8'h00 |=> zero_flag
  ) else $error("writing zero to count did not set the flag");

  stop_hold_a: assert property (
    !run && !wr_ctl && !wr_count |=> state_r.presc == 7'h7F && $stable(state_r.count)
  ) else $error("prescaler or count moved while stopped");

  presc_write_a: assert property (
    wr_presc && run && !wr_ctl |=> state_r.presc == $past(wdata[6:0])
  ) else $error("prescaler write while running not applied");

  gate_low_a: assert property (
    !dir_out && dout && !state_r.sync2 && !wr_ctl && !wr_presc
      |=> $stable(state_r.presc)
  ) else $error("gated prescaler moved with pin low");

  irq_gate_a: assert property (
    zero_flag && irq_en |-> zero_irq
  ) else $error("interrupt request missing with flag and enable");

  // Output latch steps: flag high with the pin driven, then flag low.
  // Only cycles where the pin stays an output are judged, because a switch
  // to input forces the drive low whatever the latch holds.
  sequence pdc_pin_pass_s;
    dir_out && zero_flag;
  endsequence

  sequence pdc_pin_fall_s;
    pdc_pin_pass_s ##1 (dir_out && !zero_flag);
  endsequence

  // Transparent phase: the pin shows the data bit directly
  pin_pass_a: assert property (
    pdc_pin_pass_s |-> timer_pin_out == dout
  ) else $error("output latch not transparent while the flag is high");

  // Hold phase: the pin keeps the data bit seen in the last flag-high cycle
  pin_hold_a: assert property (
    pdc_pin_fall_s |-> timer_pin_out == $past(dout)
  ) else $error("output latch did not hold the data bit after the flag fell");

  // In input modes the pin is released and its drive value parked low
  pin_input_a: assert property (
    !dir_out |-> !timer_pin_oe && !timer_pin_out
  ) else $error("timer pin driven while in an input mode");

  // A nonzero count write on the edge of the decrement to zero keeps the flag low;
  // only one register is addressed per cycle, so no control write can race
  write_wins_a: assert property (
    count_clk && wr_count && wdata != PDC_COUNT_ZERO && !zero_flag |=> !zero_flag
  ) else $error("flag set although a count write beat the decrement");

  // Software may raise the flag directly through the control register
  ctl_flag_set_a: assert property (
    wr_ctl && wdata[PDC_CTL_ZERO_BIT] |=> zero_flag
  ) else $error("writing one to the flag bit did not set it");

  // Each source event moves the running prescaler down by exactly one
  presc_dec_a: assert property (
    run && presc_clk && !wr_presc && !wr_ctl |=> state_r.presc == $past(presc_dec)
  ) else $error("prescaler did not decrement on a source event");

  // Tap code zero: every prescaler event also ticks the counter
  tap_direct_a: assert property (
    run && tap == PDC_TAP_DIRECT && presc_clk && !wr_presc && !wr_count
      |=> state_r.count == 8'($past(state_r.count) - 8'h01)
  ) else $error("direct tap did not decrement the count");

  // Clearing the run bit reloads the prescaler at the same edge
  run_clear_a: assert property (
    wr_ctl && !wdata[PDC_CTL_RUN_BIT] |=> state_r.presc == PDC_PRESC_RESET
  ) else $error("prescaler not reloaded when the run bit was cleared");

  reset_value_a: assert property (disable iff (1'b0)
    !rst_n |=> state_r.count == 8'hFF && state_r.presc == 7'h7F
               && state_r.ctl == 8'h00
  ) else $error("reset values wrong");

endmodule : pdc_timer

// *** verification/pdc_pin_source.sv ***
// Far-side model of the timer pin: event bursts or a steady gate level
`timescale 1ns/100ps
module pdc_pin_source (
  input  wire logic sys_clk,
  input  wire logic burst,
  input  wire logic gate_lvl,
  output logic      pin
);
  logic [2:0] phase_r;
  // **********
  // Burst phase
  // **********
  // Four cycles high, four low: the event rate stays at one eighth of the clock
  always_ff @(posedge sys_clk) begin
    phase_r <= burst ? phase_r + 3'h1 : 3'h0;
  end
  // Outside bursts the line sits at a defined gate level
  assign pin = burst ? phase_r[2] : gate_lvl;
endmodule : pdc_pin_source

// *** verification/pdc_timer_tb_top.sv ***
// Self-checking bench for the prescaled down counter
`timescale 1ns/100ps
module pdc_timer_tb_top
  import pdc_pkg::*;
;
  logic        sys_clk  = 1'b0;
  logic        rst_n    = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic        wr_en    = 1'b0;
  logic        rd_en    = 1'b0;
  logic [7:0]  wdata    = 8'h00;
  logic        burst    = 1'b0;
  logic        gate_lvl = 1'b0;
  logic [7:0]  rdata;
  logic        part_pin;
  logic        pin_out;
  logic        pin_oe;
  logic        zero_irq;
  logic        pin_lvl;
  integer      seed        = 32'h1D9D;
  int          err_total   = 0;
  int          comparisons = 0;

  always #20 sys_clk = ~sys_clk;
  // The design wins the wire while it drives it
  assign pin_lvl = pin_oe ? pin_out : part_pin;

  pdc_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .timer_pin_in(pin_lvl),
    .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .zero_irq(zero_irq));
  pdc_pin_source src (.sys_clk(sys_clk), .burst(burst), .gate_lvl(gate_lvl),
    .pin(part_pin));

  // **********
  // Bus tasks
  // **********
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge sys_clk);
    #1;
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    addr  = a;
    rd_en = 1'b1;
    @(posedge sys_clk);
    #1;
    rd_en = 1'b0;
    d     = rdata;
  endtask : rd
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(what, v, exp);
  endtask : rdchk
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // Expected {flag, prescaler, count} after n prescaler input events
  function automatic logic [15:0] predict(input logic [6:0] p, input logic [7:0] c,
                                          input logic [2:0] t, input int n);
    logic [6:0] np;
    logic       f;
    f = 1'b0;
    for (int i = 0; i < n; i++) begin
      np = p - 7'h01;
      if (t == 3'h0 || (!p[t-3'h1] && np[t-3'h1])) begin
        c = c - 8'h01;
        f = f | (c == 8'h00);
      end
      p = np;
    end
    return {f, p, c};
  endfunction : predict

  // **********
  // Main sequence
  // **********
  initial begin
    logic [7:0]  v;
    logic [7:0]  c0;
    logic [7:0]  ctl;
    logic [6:0]  p0;
    logic [15:0] e;
    int          n;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    rdchk("presc", PDC_ADDR_PRESC, 8'h7F);
    rdchk("count", PDC_ADDR_COUNT, 8'hFF);
    rdchk("ctl", PDC_ADDR_CTL, 8'h00);
    rdchk("unmapped", 8'hD5, 8'h00);
    wr(PDC_ADDR_PRESC, 8'h15);
    rdchk("presc refused", PDC_ADDR_PRESC, 8'h7F);
    $display("Test reset done");
    // Every tap in pin-clock mode, random start values and event counts, except tap 0 with count 03h and three events
    for (int t = 0; t < 8; t++) begin
      wr(PDC_ADDR_CTL, 8'h00);
      rdchk("presc stop", PDC_ADDR_PRESC, 8'h7F);
      ctl = {1'b0, 1'($random(seed)), 3'b001, 3'(t)};
      p0  = 7'($random(seed));
      c0  = (t == 0) ? 8'h03 : 8'($random(seed)) | 8'h01;
      n   = (t == 0) ? 3 : 8 + ($random(seed) & 32'h1F);
      wr(PDC_ADDR_CTL, ctl);
      wr(PDC_ADDR_PRESC, {1'b0, p0});
      wr(PDC_ADDR_COUNT, c0);
      rdchk("count wr", PDC_ADDR_COUNT, c0);
      rdchk("presc wr", PDC_ADDR_PRESC, {1'b0, p0});
      burst = 1'b1;
      idle(8 * n);
      burst = 1'b0;
      idle(6);
      e = predict(p0, c0, 3'(t), n);
      rdchk("presc run", PDC_ADDR_PRESC, {1'b0, e[14:8]});
      rdchk("count run", PDC_ADDR_COUNT, e[7:0]);
      rdchk("ctl flag", PDC_ADDR_CTL, {e[15], ctl[6:0]});
      check("irq", {7'h00, zero_irq}, {7'h00, e[15] & ctl[6]});
      wr(PDC_ADDR_CTL, ctl);
      $display("Test tap %0d done", t);
    end
    // Corner: count write lands on the very edge of the decrement to zero;
    // the pin rises four edges after burst and is seen three edges later
    wr(PDC_ADDR_CTL, 8'h08);
    wr(PDC_ADDR_COUNT, 8'h01);
    burst = 1'b1;
    idle(5);
    wr(PDC_ADDR_COUNT, 8'h55);
    burst = 1'b0;
    rdchk("write wins", PDC_ADDR_COUNT, 8'h55);
    rdchk("no flag", PDC_ADDR_CTL, 8'h08);
    $display("Test write race done");
    // Gated mode: no events while the pin is low, about four while high
    wr(PDC_ADDR_CTL, 8'h18);
    wr(PDC_ADDR_PRESC, 8'h40);
    idle(48);
    rdchk("gate low", PDC_ADDR_PRESC, 8'h40);
    gate_lvl = 1'b1;
    idle(48);
    gate_lvl = 1'b0;
    idle(4);
    rd(PDC_ADDR_PRESC, v);
    check("gate high", 8'((8'h40 - v) inside {[8'h03:8'h05]}), 8'h01);
    $display("Test gated done");
    // Output mode: oscillator events, transparent then holding pin latch
    wr(PDC_ADDR_CTL, 8'h38);
    wr(PDC_ADDR_PRESC, 8'h40);
    idle(48);
    rd(PDC_ADDR_PRESC, v);
    check("out osc", 8'((8'h40 - v) inside {[8'h03:8'h05]}), 8'h01);
    check("oe", {7'h00, pin_oe}, 8'h01);
    wr(PDC_ADDR_CTL, 8'hB0);
    check("pin set", {7'h00, pin_out}, 8'h01);
    wr(PDC_ADDR_CTL, 8'h20);
    check("pin held", {7'h00, pin_out}, 8'h01);
    wr(PDC_ADDR_CTL, 8'hA0);
    check("pin zero", {7'h00, pin_out}, 8'h00);
    wr(PDC_ADDR_CTL, 8'h30);
    check("pin held0", {7'h00, pin_out}, 8'h00);
    wr(PDC_ADDR_COUNT, 8'h00);
    check("pin by zero", {7'h00, pin_out}, 8'h01);
    rdchk("ctl zero wr", PDC_ADDR_CTL, 8'hB0);
    wr(PDC_ADDR_CTL, 8'h00);
    check("oe off", {6'h00, pin_oe, pin_out}, 8'h00);
    $display("Test output done");
    print_verdict();
  end

  // Watchdog: far beyond the longest expected run
  initial begin
    #(40 * 20000);
    err_total++;
    print_verdict();
  end
endmodule : pdc_timer_tb_top
